// ==== rtl/pm_pkg.sv ====
// Constants, types and register map of the PHY power-mode controller.
// Assumes a 40 MHz reference clock and an AXI4-Lite master on the bus.
// How it works
// - Expanded-control bit 11 low arms energy-detect power-down
// - Enter only armed, autoneg on, no link
// - Digital-control bit 4 auto-stops PLL then
// - Only core, transmitter and energy detect stay alive
// - Periodic link pulses, interval may be lengthened
// - Energy-detect power-down disarmed after power-up
// - Basic-control bit 11 powers down all but management
// - Clearing basic-control bit 11 leaves power-down
// - AFE bit 5 swaps crystal for slow oscillator
// - Slow oscillator plus power-down is lowest state
// - From power-down, two resets: clear, then reset
`default_nettype none
package pm_pkg;

   // ***********************************************
   // Register indices (byte address is index * 4)
   // ***********************************************
   localparam logic [7:0] IDX_BASIC_CTRL = 8'h00;
   localparam logic [7:0] IDX_DIG_CTRL   = 8'h10;
   localparam logic [7:0] IDX_AFE_CTRL   = 8'h11;
   localparam logic [7:0] IDX_EXP_CTRL   = 8'h18;
   localparam logic [7:0] IDX_PM_STATUS  = 8'h20;
   localparam logic [7:0] IDX_PM_CONFIG  = 8'h21;
   localparam int         ADDR_W         = 12;

   // ***********************************************
   // Field positions
   // ***********************************************
   localparam int BIT_SOFT_RESET   = 15;
   localparam int BIT_AN_ENABLE    = 12;
   localparam int BIT_POWER_DOWN   = 11;
   localparam int BIT_PLL_AUTO_OFF = 4;
   localparam int BIT_SLOW_OSC     = 5;
   localparam int BIT_SLEEP_OFF    = 11;
   localparam int BIT_LP_EXTEND    = 0;

   // ***********************************************
   // Reset values
   // ***********************************************
   localparam logic       RST_POWER_DOWN = 1'b0;
   localparam logic       RST_PLL_AUTO   = 1'b0;
   localparam logic       RST_SLOW_OSC   = 1'b0;
   localparam logic       RST_SLEEP_OFF  = 1'b1;
   localparam logic       RST_LP_EXTEND  = 1'b0;
   localparam logic [1:0] STRAP_WAIT     = 2'h3;

   // ***********************************************
   // Bus responses
   // ***********************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ***********************************************
   // Timing
   // ***********************************************
   localparam int CLK_FREQ_MHZ      = 40;
   localparam int LP_NORMAL_US      = 16000;
   localparam int LP_EXTENDED_US    = 64000;
   localparam int LP_NORMAL_CYCLES  = LP_NORMAL_US * CLK_FREQ_MHZ;
   localparam int LP_EXTEND_CYCLES  = LP_EXTENDED_US * CLK_FREQ_MHZ;
   localparam int LP_CNT_W          = 24;

   // Power states
   typedef enum logic [1:0] {
      ST_NORMAL = 2'b00,
      ST_SLEEP  = 2'b01,
      ST_PDOWN  = 2'b10,
      ST_LOWEST = 2'b11
   } pm_state_t;

endpackage
`default_nettype wire

// ==== rtl/pm_sync.sv ====
// Two-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pm_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   // ***********************************************
   // Sync chain
   // ***********************************************
   logic [W-1:0] meta_reg;   // First stage, read only below

   // Two stages
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         dout     <= '0;
      end else begin
         meta_reg <= din;
         dout     <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/pm_link_pulse.sv ====
// Link pulse interval timer used in energy-detect power-down.
// Assumes enable comes from a flop on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pm_link_pulse
   import pm_pkg::*;
#(
   parameter logic [LP_CNT_W-1:0] NORMAL_CYCLES = LP_CNT_W'(LP_NORMAL_CYCLES),
   parameter logic [LP_CNT_W-1:0] EXTEND_CYCLES = LP_CNT_W'(LP_EXTEND_CYCLES)
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic enable,
   input  wire logic extend,
   output logic      pulse
);
   // ***********************************************
   // Interval counter
   // ***********************************************
   logic [LP_CNT_W-1:0] cnt_reg;   // Cycles since last pulse
   logic [LP_CNT_W-1:0] cnt_next;
   logic                pulse_next;
   logic [LP_CNT_W-1:0] limit;     // Chosen interval

   // Next count and pulse
   always_comb begin
      limit      = extend ? EXTEND_CYCLES : NORMAL_CYCLES;
      cnt_next   = cnt_reg;
      pulse_next = 1'b0;
      if (!enable) begin
         cnt_next = '0;
      end else if (cnt_reg >= limit - 1'b1) begin
         cnt_next   = '0;
         pulse_next = 1'b1;
      end else begin
         cnt_next = cnt_reg + 1'b1;
      end
   end

   // Register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
         pulse   <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         pulse   <= pulse_next;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/pm_ctrl.sv ====
// Power-mode controller top: AXI4-Lite register slave plus power FSM.
// Assumes link, energy and strap pins are asynchronous to clk.
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pm_ctrl #(
   parameter int LP_NORMAL = pm_pkg::LP_NORMAL_CYCLES,
   parameter int LP_EXTEND = pm_pkg::LP_EXTEND_CYCLES
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   // AXI4-Lite write address
   input  wire logic [pm_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [pm_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // Pins
   input  wire logic                      link_up_pin,
   input  wire logic                      energy_seen_pin,
   input  wire logic                      an_strap_pin,
   // Power controls
   output logic                           core_enable,
   output logic                           xcvr_enable,
   output logic                           tx_enable,
   output logic                           energy_detect_enable,
   output logic                           pll_off,
   output logic                           crystal_input_off,
   output logic                           link_pulse,
   output logic                           soft_reset_pulse
);
   import pm_pkg::*;

   // ***********************************************
   // Pin synchronisers
   // ***********************************************
   logic [2:0] pins_sync;   // {strap, energy, link}
   logic       link_s;      // Link present
   logic       energy_s;    // Energy on the line
   logic       strap_s;     // Autoneg strap level

   pm_sync #(.W(3)) pm_sync_i (
      .clk  (clk),
      .rst  (rst),
      .din  ({an_strap_pin, energy_seen_pin, link_up_pin}),
      .dout (pins_sync)
   );
   assign link_s   = pins_sync[0];
   assign energy_s = pins_sync[1];
   assign strap_s  = pins_sync[2];

   // ***********************************************
   // Control state
   // ***********************************************
   logic       pdown_reg, pdown_next;       // Power-down
   logic       an_en_reg, an_en_next;       // Autoneg enable
   logic       pll_auto_reg, pll_auto_next; // PLL auto-off
   logic       slow_reg, slow_next;         // Slow oscillator
   logic       sleep_off_reg, sleep_off_next; // Energy-detect PD off
   logic       lp_ext_reg, lp_ext_next;     // Long pulse interval
   logic [1:0] strap_cnt_reg, strap_cnt_next; // Strap latch delay
   logic       srst_next;                   // Soft reset pulse

   // ***********************************************
   // Bus state
   // ***********************************************
   logic                awready_next, wready_next, bvalid_next;
   logic                arready_next, rvalid_next;
   logic [1:0]          bresp_next, rresp_next;
   logic [31:0]         rdata_next;
   logic                aw_held_reg, aw_held_next; // Address captured
   logic                w_held_reg, w_held_next;   // Data captured
   logic [ADDR_W-1:0]   awaddr_reg, awaddr_next;
   logic [31:0]         wdata_reg, wdata_next;
   logic [3:0]          wstrb_reg, wstrb_next;

   // ***********************************************
   // Power FSM state
   // ***********************************************
   pm_state_t state_reg, state_next;
   logic      core_next, xcvr_next, tx_next, ed_next;
   logic      pll_next, xtal_next;

   // Helpers
   logic [7:0]  widx;      // Write register index
   logic        wmapped;   // Write hits a register
   logic [15:0] wmask;     // Byte-lane mask
   logic [15:0] wval;      // Merged write value
   logic [15:0] old;       // Current register value
   logic [7:0]  ridx;      // Read register index
   logic [15:0] rval;      // Read value
   logic        rmapped;   // Read hits a register

   // Register read view
   function automatic logic [15:0] reg_view(input logic [7:0] idx);
      logic [15:0] v;
      v = 16'h0000;
      case (idx)
         IDX_BASIC_CTRL: begin
            v[BIT_AN_ENABLE]  = an_en_reg;
            v[BIT_POWER_DOWN] = pdown_reg;
         end
         IDX_DIG_CTRL:  v[BIT_PLL_AUTO_OFF] = pll_auto_reg;
         IDX_AFE_CTRL:  v[BIT_SLOW_OSC]     = slow_reg;
         IDX_EXP_CTRL:  v[BIT_SLEEP_OFF]    = sleep_off_reg;
         IDX_PM_CONFIG: v[BIT_LP_EXTEND]    = lp_ext_reg;
         IDX_PM_STATUS: v = {8'h00, link_s, energy_s, pll_off,
                             crystal_input_off, 2'h0, state_reg};
         default:       v = 16'h0000;
      endcase
      return v;
   endfunction

   // Map check
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      i = a[9:2];
      return (a[ADDR_W-1:10] == '0) &&
             (i == IDX_BASIC_CTRL || i == IDX_DIG_CTRL ||
              i == IDX_AFE_CTRL || i == IDX_EXP_CTRL ||
              i == IDX_PM_STATUS || i == IDX_PM_CONFIG);
   endfunction

   // ***********************************************
   // Bus and register next values
   // ***********************************************
   always_comb begin
      aw_held_next   = aw_held_reg;
      w_held_next    = w_held_reg;
      awaddr_next    = awaddr_reg;
      wdata_next     = wdata_reg;
      wstrb_next     = wstrb_reg;
      bvalid_next    = s_axi_bvalid;
      bresp_next     = s_axi_bresp;
      rvalid_next    = s_axi_rvalid;
      rresp_next     = s_axi_rresp;
      rdata_next     = s_axi_rdata;
      arready_next   = s_axi_arready;
      pdown_next     = pdown_reg;
      an_en_next     = an_en_reg;
      pll_auto_next  = pll_auto_reg;
      slow_next      = slow_reg;
      sleep_off_next = sleep_off_reg;
      lp_ext_next    = lp_ext_reg;
      strap_cnt_next = strap_cnt_reg;
      srst_next      = 1'b0;
      widx           = awaddr_reg[9:2];
      wmapped        = is_mapped(awaddr_reg);
      wmask          = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
      old            = reg_view(widx);
      wval           = (old & ~wmask) | (wdata_reg[15:0] & wmask);
      ridx           = s_axi_araddr[9:2];
      rmapped        = is_mapped(s_axi_araddr);
      rval           = reg_view(ridx);

      // Strap latched after reset release, once synced
      if (strap_cnt_reg != 2'h0) begin
         strap_cnt_next = strap_cnt_reg - 2'h1;
         if (strap_cnt_reg == 2'h1) begin
            an_en_next = strap_s;
         end
      end

      // Capture address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_next = 1'b1;
         awaddr_next  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_next = 1'b1;
         wdata_next  = s_axi_wdata;
         wstrb_next  = s_axi_wstrb;
      end

      // Response taken
      if (s_axi_bvalid && s_axi_bready) begin
         bvalid_next = 1'b0;
      end

      // writes accepted in every power state
      if (aw_held_reg && w_held_reg && !s_axi_bvalid) begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = wmapped ? RESP_OKAY : RESP_SLVERR;
         case (widx)
            IDX_BASIC_CTRL: begin
               if (wmapped && wval[BIT_SOFT_RESET]) begin
                  if (pdown_reg) begin
                     pdown_next = 1'b0;
                  end else begin
                     // Second reset: defaults, re-latch strap
                     // final reset step of slow exit
                     srst_next      = 1'b1;
                     pdown_next     = RST_POWER_DOWN;
                     pll_auto_next  = RST_PLL_AUTO;
                     slow_next      = RST_SLOW_OSC;
                     sleep_off_next = RST_SLEEP_OFF;
                     lp_ext_next    = RST_LP_EXTEND;
                     strap_cnt_next = STRAP_WAIT;
                  end
               end else if (wmapped) begin
                  pdown_next = wval[BIT_POWER_DOWN];
                  an_en_next = wval[BIT_AN_ENABLE];
               end
            end
            IDX_DIG_CTRL:  pll_auto_next = wval[BIT_PLL_AUTO_OFF];
            IDX_AFE_CTRL:  slow_next = wval[BIT_SLOW_OSC];
            IDX_EXP_CTRL:  sleep_off_next = wval[BIT_SLEEP_OFF];
            IDX_PM_CONFIG: lp_ext_next = wval[BIT_LP_EXTEND];
            default:       ;
         endcase
      end

      // Each ready while its own channel holds nothing
      awready_next = !aw_held_next;
      wready_next  = !w_held_next;

      // Read channel: one at a time
      if (s_axi_rvalid && s_axi_rready) begin
         rvalid_next  = 1'b0;
         arready_next = 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next  = 1'b1;
         arready_next = 1'b0;
         rdata_next   = {16'h0000, rmapped ? rval : 16'h0000};
         rresp_next   = rmapped ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // ***********************************************
   // Power state next values
   // ***********************************************
   always_comb begin
      if (pdown_reg && slow_reg) begin
         state_next = ST_LOWEST;
      end else if (pdown_reg) begin
         state_next = ST_PDOWN;
      end else if (!sleep_off_reg && an_en_reg && !link_s) begin
         state_next = ST_SLEEP;
      end else begin
         state_next = ST_NORMAL;
      end

      // Block enables per state
      core_next = 1'b0;
      xcvr_next = 1'b0;
      tx_next   = 1'b0;
      ed_next   = 1'b0;
      pll_next  = 1'b1;
      case (state_next)
         ST_NORMAL: begin
            core_next = 1'b1;
            xcvr_next = 1'b1;
            tx_next   = 1'b1;
            ed_next   = 1'b1;
            pll_next  = 1'b0;
         end
         ST_SLEEP: begin
            core_next = 1'b1;
            tx_next   = 1'b1;
            ed_next   = 1'b1;
            pll_next  = pll_auto_reg;
         end
         ST_PDOWN:  pll_next = 1'b1;
         ST_LOWEST: pll_next = 1'b1;
         default:   pll_next = 1'b1;
      endcase
      xtal_next = slow_reg;
   end

   // ***********************************************
   // Link pulse timer
   // ***********************************************
   // periodic pulses while asleep
   pm_link_pulse #(
      .NORMAL_CYCLES (LP_CNT_W'(LP_NORMAL)),
      .EXTEND_CYCLES (LP_CNT_W'(LP_EXTEND))
   ) pm_link_pulse_i (
      .clk    (clk),
      .rst    (rst),
      .enable (state_reg == ST_SLEEP),
      .extend (lp_ext_reg),
      .pulse  (link_pulse)
   );

   // ***********************************************
   // Registers
   // ***********************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_awready        <= 1'b1;
         s_axi_wready         <= 1'b1;
         s_axi_bvalid         <= 1'b0;
         s_axi_bresp          <= RESP_OKAY;
         s_axi_arready        <= 1'b1;
         s_axi_rvalid         <= 1'b0;
         s_axi_rresp          <= RESP_OKAY;
         s_axi_rdata          <= 32'h0000_0000;
         aw_held_reg          <= 1'b0;
         w_held_reg           <= 1'b0;
         awaddr_reg           <= '0;
         wdata_reg            <= 32'h0000_0000;
         wstrb_reg            <= 4'h0;
         pdown_reg            <= RST_POWER_DOWN;
         an_en_reg            <= 1'b0;
         pll_auto_reg         <= RST_PLL_AUTO;
         slow_reg             <= RST_SLOW_OSC;
         sleep_off_reg        <= RST_SLEEP_OFF;
         lp_ext_reg           <= RST_LP_EXTEND;
         strap_cnt_reg        <= STRAP_WAIT;
         soft_reset_pulse     <= 1'b0;
         state_reg            <= ST_NORMAL;
         core_enable          <= 1'b0;
         xcvr_enable          <= 1'b0;
         tx_enable            <= 1'b0;
         energy_detect_enable <= 1'b0;
         pll_off              <= 1'b0;
         crystal_input_off    <= 1'b0;
      end else begin
         s_axi_awready        <= awready_next;
         s_axi_wready         <= wready_next;
         s_axi_bvalid         <= bvalid_next;
         s_axi_bresp          <= bresp_next;
         s_axi_arready        <= arready_next;
         s_axi_rvalid         <= rvalid_next;
         s_axi_rresp          <= rresp_next;
         s_axi_rdata          <= rdata_next;
         aw_held_reg          <= aw_held_next;
         w_held_reg           <= w_held_next;
         awaddr_reg           <= awaddr_next;
         wdata_reg            <= wdata_next;
         wstrb_reg            <= wstrb_next;
         pdown_reg            <= pdown_next;
         an_en_reg            <= an_en_next;
         pll_auto_reg         <= pll_auto_next;
         slow_reg             <= slow_next;
         sleep_off_reg        <= sleep_off_next;
         lp_ext_reg           <= lp_ext_next;
         strap_cnt_reg        <= strap_cnt_next;
         soft_reset_pulse     <= srst_next;
         state_reg            <= state_next;
         core_enable          <= core_next;
         xcvr_enable          <= xcvr_next;
         tx_enable            <= tx_next;
         energy_detect_enable <= ed_next;
         pll_off              <= pll_next;
         crystal_input_off    <= xtal_next;
      end
   end
endmodule
`default_nettype wire

// ==== dv/pm_ctrl_props.sv ====
// Port assertions for the power-mode controller.
// Assumes a bind onto pm_ctrl; clk rising, rst high.
`timescale 1ns/1ps
`default_nettype none
module pm_ctrl_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic link_up_pin,
   input wire logic core_enable,
   input wire logic xcvr_enable,
   input wire logic tx_enable,
   input wire logic energy_detect_enable,
   input wire logic pll_off,
   input wire logic link_pulse,
   input wire logic soft_reset_pulse
);
   logic up; // Outputs valid one edge after reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) up <= 1'b0;
      else up <= 1'b1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sleep_blocks_a: assert property (core_enable && !xcvr_enable |-> tx_enable && energy_detect_enable)
      else $error("sleep block enables wrong");
   pd_all_off_a: assert property (up && !core_enable |-> !tx_enable && !xcvr_enable && pll_off)
      else $error("power-down left blocks on");
   pll_sleep_a: assert property (pll_off && core_enable |-> !xcvr_enable)
      else $error("pll off outside sleep");
   link_wakes_a: assert property (link_up_pin [*5] |-> xcvr_enable || !core_enable)
      else $error("sleep held with link up");
   pulse_width_a: assert property (link_pulse |=> !link_pulse)
      else $error("link pulse too long");
   srst_width_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
      else $error("reset pulse too long");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid |-> ##2 s_axi_bvalid)
      else $error("write not answered");
   cover property (link_pulse);
   cover property (soft_reset_pulse);
   cover property (up && !core_enable);
endmodule
`default_nettype wire

// ==== dv/sta_mgmt.sv ====
// Management controller model: AXI4-Lite master tasks.
// Assumes the slave shares clk; callers run after an edge.
`timescale 1ns/1ps
`default_nettype none
module sta_mgmt (
   input  wire logic                 clk,
   output logic [pm_pkg::ADDR_W-1:0] s_axi_awaddr,
   output logic                      s_axi_awvalid,
   input  wire logic                 s_axi_awready,
   output logic [31:0]               s_axi_wdata,
   output logic [3:0]                s_axi_wstrb,
   output logic                      s_axi_wvalid,
   input  wire logic                 s_axi_wready,
   input  wire logic [1:0]           s_axi_bresp,
   input  wire logic                 s_axi_bvalid,
   output logic                      s_axi_bready,
   output logic [pm_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic                      s_axi_arvalid,
   input  wire logic                 s_axi_arready,
   input  wire logic [31:0]          s_axi_rdata,
   input  wire logic [1:0]           s_axi_rresp,
   input  wire logic                 s_axi_rvalid,
   output logic                      s_axi_rready
);
   initial begin
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
   end
   // one write at a time, in call order
   task automatic wr(input logic [11:0] a, input logic [31:0] dt, output logic [1:0] rs);
      logic b;
      b = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dt;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            b = 1'b1;
            rs = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
   endtask
   // Read: address held until taken, rready until data
   task automatic rd(input logic [11:0] a, output logic [31:0] dt, output logic [1:0] rs);
      logic b;
      b = 1'b0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!b) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            b = 1'b1;
            dt = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end
   endtask
endmodule
`default_nettype wire

// ==== dv/pm_ctrl_tb.sv ====
// Self-checking bench for the power-mode controller.
// Assumes sta_mgmt drives the bus, the bench the pins.
`timescale 1ns/1ps
`default_nettype none
module pm_ctrl_tb;
   import pm_pkg::*;
   logic clk = 0, rst = 1;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic link_up_pin = 0, energy_seen_pin = 0, an_strap_pin = 1;
   logic core_enable, xcvr_enable, tx_enable, energy_detect_enable;
   logic pll_off, crystal_input_off, link_pulse, soft_reset_pulse;
   int n_errors = 0, cmp_count = 0, n_pulse = 0, n_srst = 0;
   pm_ctrl #(.LP_NORMAL(8), .LP_EXTEND(20)) pm_ctrl_i (.*);
   sta_mgmt sta_mgmt_i (.*);
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (link_pulse) n_pulse++;
      if (soft_reset_pulse) n_srst++;
   end
   task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      sta_mgmt_i.rd(a, d, r);
      chk("rd", {(a > 12'h3ff) ? RESP_SLVERR : RESP_OKAY, e}, {r, d});
   endtask
   task automatic wrc(input logic [11:0] a, input logic [31:0] v);
      sta_mgmt_i.wr(a, v, r);
      chk("wr", (a > 12'h3ff) ? RESP_SLVERR : RESP_OKAY, r);
   endtask
   task automatic st(input logic [31:0] e);
      repeat (4) @(posedge clk);
      rdc(12'h080, e);
   endtask
   task automatic pulses(input int lo, input int hi);
      n_pulse = 0;
      repeat (80) @(posedge clk);
      chk("pulses", 1, n_pulse inside {[lo:hi]});
   endtask
   task automatic report_and_stop;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      n_errors++;
      report_and_stop;
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      chk("xcvr", 1, xcvr_enable);
      rdc(12'h060, 32'h800);
      rdc(12'h000, 32'h1000);
      wrc(12'h060, 0);
      st(32'h1);
      chk("blocks", 4'b1110, {core_enable, tx_enable, energy_detect_enable, xcvr_enable});
      pulses(8, 11);
      wrc(12'h084, 1);
      pulses(3, 5);
      wrc(12'h040, 32'h10);
      st(32'h21);
      link_up_pin <= 1'b1;
      energy_seen_pin <= 1'b1;
      st(32'hc0);
      link_up_pin <= 1'b0;
      energy_seen_pin <= 1'b0;
      wrc(12'h000, 0);
      st(0);
      wrc(12'h000, 32'h1800);
      st(32'h22);
      chk("pd_blocks", 0, {core_enable, tx_enable, energy_detect_enable, xcvr_enable});
      rdc(12'h040, 32'h10);
      wrc(12'h044, 32'h20);
      st(32'h33);
      chk("xtal", 1, crystal_input_off);
      wrc(12'h044, 0);
      wrc(12'h000, 32'h1000);
      st(32'h21);
      wrc(12'h000, 32'h9000);
      st(0);
      chk("srst", 1, n_srst);
      rdc(12'h040, 0);
      wrc(12'h000, 32'h1800);
      wrc(12'h000, 32'h9800);
      rdc(12'h000, 32'h1000);
      an_strap_pin <= 1'b0;
      wrc(12'h000, 32'h8000);
      st(0);
      chk("srst", 2, n_srst);
      rdc(12'h000, 0);
      rdc(12'h400, 0);
      wrc(12'h400, 32'hffff);
      report_and_stop;
   end
endmodule
bind pm_ctrl pm_ctrl_props pm_ctrl_props_i (.*);
`default_nettype wire
